// [hw/drl_map.svh]
// Constants for the status lamp controller.
// Assumes a 200 MHz clock; included by bare name.
`ifndef DRL_MAP_SVH
`define DRL_MAP_SVH

`define DRL_CLK_PERIOD_NS   32'h0000_0005
`define DRL_HALF_PERIOD_NS  32'h1DCD_6500
`define DRL_HALF_CYCLES     (`DRL_HALF_PERIOD_NS / `DRL_CLK_PERIOD_NS)
`define DRL_BLINK_START_LIT 1'b1
`define DRL_SENSE_ON_IDLE   1'b0
`define DRL_LAMP_LIT        1'b0
`define DRL_LAMP_DARK       1'b1

`endif

// [hw/drl_pkg.sv]
// Types for the status lamp controller.
// Assumes drl_map.svh supplies all constants.
`default_nettype none
package drl_pkg;

    typedef enum logic [1:0] {
        SPIN_STOPPED,
        SPIN_AT_SPEED,
        SPIN_ACCEL,
        SPIN_DECEL
    } drl_spin_e;

    typedef struct packed {
        drl_spin_e   spin;
        logic        cmd_active;
        logic        format_active;
        logic        cyl_change;
    } drl_status_s;

    typedef struct packed {
        drl_spin_e   spin_prev;
        logic        fmt_prev;
        logic [31:0] blink_cnt;
        logic        blink_lit;
        logic        fmt_lit;
        logic        lamp_lit;
    } drl_state_s;

endpackage

`default_nettype wire

// [hw/drl_lamp.sv]
// Status lamp controller: drives the open-drain ready lamp pin.
// Assumes status inputs come from logic on REF_CLK.
//
// Summary of operation
// - Lamp sense select bit picks meaning: 0 first behaviour, 1 second.
// - Spindle stopped, no command: lamp off regardless of sense bit.
// - Spindle stopped, command executing: lamp on regardless of sense bit.
// - At speed, idle: lamp on if sense 0, off if sense 1.
// - At speed, command executing: lamp off if sense 0, on if sense 1.
// - Spinning up or down: blink 0.5 s on, 0.5 s off.
// - Format in progress: invert lamp on each cylinder change.
// - Pin pulled low lights lamp, released high darkens it.
`timescale 1ns/100ps
`default_nettype none
`include "drl_map.svh"

module drl_lamp (
    input  wire logic                 REF_CLK,
    input  wire logic                 RESET_N,
    input  wire logic                 CLK_EN,
    input  wire drl_pkg::drl_status_s STATUS,
    input  wire logic                 LAMP_SENSE_SELECT,
    output logic                      STATUS_LAMP_DRIVE_O,
    output logic                      STATUS_LAMP_DRIVE_OE_N
);

    localparam logic [31:0] HALF_CNT = 32'(`DRL_HALF_CYCLES);

    // State after reset: lamp dark, blink and format phases cleared
    localparam drl_pkg::drl_state_s RESET_STATE = '{
        spin_prev: drl_pkg::SPIN_STOPPED,
        fmt_prev:  1'b0,
        blink_cnt: 32'h0000_0000,
        blink_lit: 1'b0,
        fmt_lit:   1'b0,
        lamp_lit:  1'b0
    };

    drl_pkg::drl_state_s st_reg;
    drl_pkg::drl_state_s st_next;

    function automatic logic steady_lit(input drl_pkg::drl_spin_e sp, input logic cmd, input logic sel);
        logic r;
        r = 1'b0;
        case (sp)
            drl_pkg::SPIN_STOPPED: begin
                r = cmd;
            end
            drl_pkg::SPIN_AT_SPEED: begin
                if (sel == `DRL_SENSE_ON_IDLE) begin
                    r = !cmd;
                end else begin
                    r = cmd;
                end
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Spin-up or spin-down in progress
    function automatic logic spin_moving(input drl_pkg::drl_spin_e sp);
        logic r;
        r = 1'b0;
        case (sp)
            drl_pkg::SPIN_ACCEL: r = 1'b1;
            drl_pkg::SPIN_DECEL: r = 1'b1;
            default:             r = 1'b0;
        endcase
        return r;
    endfunction

    logic spinning;
    logic spin_enter;
    logic blink_wrap;
    logic fmt_start;
    logic fmt_step;
    assign spinning   = spin_moving(STATUS.spin);
    assign spin_enter = spinning && (STATUS.spin != st_reg.spin_prev);
    assign blink_wrap = (st_reg.blink_cnt == HALF_CNT - 32'h0000_0001);
    assign fmt_start  = STATUS.format_active && !st_reg.fmt_prev;
    assign fmt_step   = STATUS.format_active && STATUS.cyl_change;

    always_comb begin
        st_next = st_reg;
        st_next.spin_prev = STATUS.spin;
        st_next.fmt_prev  = STATUS.format_active;

        // Blink timebase
        if (spin_enter) begin
            st_next.blink_cnt = 32'h0000_0000;
            st_next.blink_lit = `DRL_BLINK_START_LIT;
        end else if (spinning) begin
            if (blink_wrap) begin
                st_next.blink_cnt = 32'h0000_0000;
                st_next.blink_lit = !st_reg.blink_lit;
            end else begin
                st_next.blink_cnt = st_reg.blink_cnt + 32'h0000_0001;
            end
        end

        // Format phase: start from shown lamp, flip per cylinder
        if (fmt_start) begin
            st_next.fmt_lit = st_reg.lamp_lit;
        end
        if (fmt_step) begin
            st_next.fmt_lit = !(st_reg.fmt_prev ? st_reg.fmt_lit : st_reg.lamp_lit);
        end

        // Lamp source: format over blink over steady table
        if (STATUS.format_active) begin
            st_next.lamp_lit = st_next.fmt_lit;
        end else if (spinning) begin
            st_next.lamp_lit = st_next.blink_lit;
        end else begin
            st_next.lamp_lit = steady_lit(STATUS.spin, STATUS.cmd_active, LAMP_SENSE_SELECT);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            st_reg <= RESET_STATE;
        end else if (CLK_EN) begin
            st_reg <= st_next;
        end
    end

    // Open drain: sink only, enable low while sinking
    assign STATUS_LAMP_DRIVE_O    = `DRL_LAMP_LIT;
    assign STATUS_LAMP_DRIVE_OE_N = st_reg.lamp_lit ? `DRL_LAMP_LIT : `DRL_LAMP_DARK;

    // Steady table
    chk_idle_dark: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && !STATUS.format_active && STATUS.spin == drl_pkg::SPIN_STOPPED && !STATUS.cmd_active
        |=> !st_reg.lamp_lit)
        else $error("lamp lit while stopped and idle");

    chk_stop_cmd: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && !STATUS.format_active && STATUS.spin == drl_pkg::SPIN_STOPPED && STATUS.cmd_active
        |=> st_reg.lamp_lit)
        else $error("lamp dark while stopped with command");

    chk_speed_idle: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && !STATUS.format_active && STATUS.spin == drl_pkg::SPIN_AT_SPEED && !STATUS.cmd_active
        |=> st_reg.lamp_lit == !$past(LAMP_SENSE_SELECT))
        else $error("wrong lamp at speed idle");

    chk_speed_cmd: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && !STATUS.format_active && STATUS.spin == drl_pkg::SPIN_AT_SPEED && STATUS.cmd_active
        |=> st_reg.lamp_lit == $past(LAMP_SENSE_SELECT))
        else $error("wrong lamp at speed busy");

    // Blink timebase
    chk_blink_restart: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && spin_enter
        |=> st_reg.blink_cnt == 32'h0000_0000 && st_reg.blink_lit)
        else $error("blink phase not restarted");

    chk_blink_bound: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        st_reg.blink_cnt < HALF_CNT)
        else $error("blink counter past half period");

    chk_blink_shown: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && !STATUS.format_active && spinning
        |=> st_reg.lamp_lit == st_reg.blink_lit)
        else $error("lamp not following blink phase");

    chk_blink_toggle: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && spinning && !spin_enter && blink_wrap
        |=> st_reg.blink_lit != $past(st_reg.blink_lit) && st_reg.blink_cnt == 32'h0000_0000)
        else $error("blink phase not flipped at half period");

    chk_blink_count: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && spinning && !spin_enter && !blink_wrap
        |=> st_reg.blink_cnt == $past(st_reg.blink_cnt) + 32'h0000_0001)
        else $error("blink counter did not advance");

    chk_blink_idle: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && !spinning
        |=> $stable(st_reg.blink_cnt))
        else $error("blink counter moved outside spin change");

    // Format toggling
    chk_fmt_toggle: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && STATUS.format_active && st_reg.fmt_prev && STATUS.cyl_change
        |=> st_reg.lamp_lit != $past(st_reg.lamp_lit))
        else $error("no toggle on cylinder change");

    chk_fmt_entry: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && fmt_start && !STATUS.cyl_change
        |=> st_reg.lamp_lit == $past(st_reg.lamp_lit))
        else $error("lamp changed on format entry");

    chk_fmt_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && STATUS.format_active && st_reg.fmt_prev && !STATUS.cyl_change
        |=> $stable(st_reg.lamp_lit))
        else $error("lamp moved between cylinder changes");

    chk_fmt_priority: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        CLK_EN && STATUS.format_active
        |=> st_reg.lamp_lit == st_reg.fmt_lit)
        else $error("format phase not shown on lamp");

    // Pin, reset and clock enable
    chk_pin_level: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        st_reg.lamp_lit == !STATUS_LAMP_DRIVE_OE_N && STATUS_LAMP_DRIVE_O == 1'b0)
        else $error("pin drive mismatched");

    chk_reset_dark: assert property (@(posedge REF_CLK)
        !RESET_N
        |=> STATUS_LAMP_DRIVE_OE_N == `DRL_LAMP_DARK)
        else $error("lamp lit after reset");

    chk_freeze_state: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !CLK_EN
        |=> $stable(st_reg))
        else $error("state moved while clock enable low");

    cov_blink: cover property (@(posedge REF_CLK) disable iff (!RESET_N) spinning && $rose(st_reg.blink_lit));
    cov_fmt:   cover property (@(posedge REF_CLK) disable iff (!RESET_N) STATUS.format_active && STATUS.cyl_change);
    cov_sense: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
        STATUS.spin == drl_pkg::SPIN_AT_SPEED && LAMP_SENSE_SELECT && st_reg.lamp_lit);
    cov_freeze: cover property (@(posedge REF_CLK) disable iff (!RESET_N) !CLK_EN && st_reg.lamp_lit);
    cov_decel:  cover property (@(posedge REF_CLK) disable iff (!RESET_N)
        spin_enter && STATUS.spin == drl_pkg::SPIN_DECEL);

endmodule

`default_nettype wire

// [tb/drl_lamp_model.sv]
// Lamp and resistor model at the status pin.
// Assumes a released pin is pulled up to the lamp supply.
`timescale 1ns/100ps
`default_nettype none
module drl_lamp_model (
    input  wire logic PIN_O,
    input  wire logic PIN_OE_N,
    output logic      LAMP_ON
);
    // Pull-up when released, sink lights lamp
    assign LAMP_ON = ~(PIN_OE_N ? 1'b1 : PIN_O);
endmodule
`default_nettype wire

// [tb/test_drive_ready_lamp_control.sv]
// Self-checking bench for the status lamp controller.
// Assumes blink half period far longer than this run.
`timescale 1ns/100ps
`default_nettype none
module test_drive_ready_lamp_control;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 en = 1'b1;
    logic                 sel = 1'b0;
    drl_pkg::drl_status_s st = '0;
    logic                 p_o, p_oe_n, lit, v, c, m;
    logic [1:0]           s;
    int                   n_fail = 0, comparisons = 0;
    drl_lamp dut (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .STATUS(st), .LAMP_SENSE_SELECT(sel),
        .STATUS_LAMP_DRIVE_O(p_o), .STATUS_LAMP_DRIVE_OE_N(p_oe_n));
    drl_lamp_model lamp (.PIN_O(p_o), .PIN_OE_N(p_oe_n), .LAMP_ON(lit));
    initial forever #2.5 clk = ~clk;
    function automatic logic want(logic [1:0] s, logic c, logic m);
        return (s == 2'h0) ? c : (c ^ ~m);
    endfunction
    task automatic check(string what, logic seen, logic exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic put(logic [1:0] s, logic c, logic f, logic y, logic m);
        @(posedge clk);
        st <= '{drl_pkg::drl_spin_e'(s), c, f, y};
        sel <= m;
        @(posedge clk);
        st.cyl_change <= 1'b0;
        #1;
    endtask
    task automatic stop_test;
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(75659));
        repeat (3) @(posedge clk);
        #1;
        check("reset lamp", lit, 1'b0);
        @(posedge clk) rst_n <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            s = 2'($urandom_range(1, 0));
            c = 1'($urandom);
            m = 1'($urandom);
            put(s, c, 1'b0, 1'($urandom), m);
            check("table lamp", lit, want(s, c, m));
        end
        for (int k = 2; k < 4; k++) begin
            put(2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
            check("dark before spin", lit, 1'b0);
            put(2'(k), 1'($urandom), 1'b0, 1'($urandom), 1'($urandom));
            repeat (50) begin
                check("blink phase", lit, 1'b1);
                @(posedge clk);
                #1;
            end
        end
        put(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        put(2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        check("format entry", lit, 1'b1);
        v = 1'b1;
        for (int i = 0; i < 6; i++) begin
            put(2'(i % 4), 1'b0, 1'b1, 1'b1, i[0]);
            v = ~v;
            check("format toggle", lit, v);
        end
        put(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge clk) en <= 1'b0;
        put(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        check("frozen lamp", lit, 1'b1);
        @(posedge clk) en <= 1'b1;
        @(posedge clk);
        #1;
        check("thawed lamp", lit, 1'b0);
        put(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk);
        #1;
        check("mid reset lamp", lit, 1'b0);
        @(posedge clk) rst_n <= 1'b1;
        put(2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        check("after reset lamp", lit, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
